// File: bench/test_voltage_reference_control.sv
`timescale 1ns/1ps
module test_voltage_reference_control;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  factory_trim = 8'h00;
   logic        clock_gate_ctrl_one = 1'b1;
   logic        third_stop_mode = 1'b0;
   logic [1:0]  avs_address = 2'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  trim_code;
   logic        bandgap_en;
   logic        lp_buf_en;
   logic        tight_buf_en;
   logic        reference_out_pin_en;
   logic        irq;
   logic [31:0] rd;
   logic [7:0]  v;
   logic [7:0]  corner [4] = '{8'h80, 8'h7f, 8'h00, 8'hff};
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;

   vref_ctrl #(.STARTUP_CYCLES(8)) uut (.sys_clk, .srst, .factory_trim, .clock_gate_ctrl_one,
      .third_stop_mode, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .trim_code, .bandgap_en,
      .lp_buf_en, .tight_buf_en, .reference_out_pin_en, .irq);

   initial forever #25 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic req(input logic w, input logic [1:0] a, input logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      third_stop_mode <= 1'($urandom);
   endtask

   task automatic fin(output logic [31:0] q);
      @(posedge sys_clk);
      while (avs_waitrequest)
         @(posedge sys_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      req(w, a, d);
      fin(rd);
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      factory_trim <= 8'($urandom);
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      bus(1'b0, 2'h0, 32'h0);
      chk(rd, 32'(factory_trim));
      bus(1'b0, 2'h1, 32'h0);
      chk(rd, 32'h0);
   endtask

   function automatic logic [2:0] outs(input logic [7:0] sc);
      logic en;
      en = sc[7] && sc[1:0] != 2'h3;
      return {en, en && sc[1:0] == 2'h1, en && sc[1:0] == 2'h2};
   endfunction

   task automatic chk_sc(input logic [7:0] sc, input logic st);
      bus(1'b0, 2'h1, 32'h0);
      chk(rd, {24'h0, sc[7], 4'h0, st, sc[1:0]});
      chk(32'({bandgap_en, lp_buf_en, tight_buf_en}), 32'(outs(sc)));
      chk(32'(reference_out_pin_en), 32'(outs(sc) & 3'h1));
   endtask

   initial
   begin
      void'($urandom(32'h76efafb9));
      do_reset();
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         v = (i < 4) ? corner[i] : 8'($urandom);
         bus(1'b1, 2'h0, {24'($urandom), v});
         bus(1'b0, 2'h0, 32'h0);
         chk(rd, 32'(v));
         chk(32'(trim_code), 32'(v));
      end
      $display("test trim done");
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, 2'h1, 32'(m));
         chk_sc(8'(m), 1'b0);
         bus(1'b1, 2'h1, 32'h78 | 32'(m) | 32'h80);
         chk_sc(8'h80 | 8'(m), 1'b0);
         repeat (20) @(posedge sys_clk);
         chk_sc(8'h80 | 8'(m), m != 3);
      end
      $display("test modes done");
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'h3);
      chk(32'(irq), 32'h0);
      bus(1'b1, 2'h3, 32'h3);
      bus(1'b0, 2'h3, 32'h0);
      chk(rd, 32'h3);
      chk(32'(irq), 32'h1);
      bus(1'b1, 2'h1, 32'h0);
      bus(1'b1, 2'h2, 32'h3);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'h0);
      chk(32'(irq), 32'h0);
      bus(1'b1, 2'h1, 32'h80);
      bus(1'b0, 2'h1, 32'h0);
      while (!rd[2])
         bus(1'b0, 2'h1, 32'h0);
      bus(1'b1, 2'h1, 32'h82);
      chk_sc(8'h82, 1'b1);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'h1);
      $display("test irq done");
      clock_gate_ctrl_one <= 1'b0;
      repeat (2) @(posedge sys_clk);
      req(1'b0, 2'h0, 32'h0);
      repeat (6)
      begin
         @(posedge sys_clk);
         chk(32'(avs_waitrequest), 32'h1);
      end
      clock_gate_ctrl_one <= 1'b1;
      fin(rd);
      chk(rd, 32'(v));
      $display("test gate done");
      do_reset();
      $display("test second reset done");
      complete_run();
   end
endmodule

// File: bench/vref_ctrl_props.sv
`timescale 1ns/1ps
module vref_ctrl_props
#(
   parameter int unsigned STARTUP_CYCLES = 8
)
(
   input logic        sys_clk,
   input logic        srst,
   input logic [7:0]  factory_trim,
   input logic        clock_gate_ctrl_one,
   input logic [1:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0]  avs_byteenable,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic [7:0]  trim_code,
   input logic        bandgap_en,
   input logic        lp_buf_en,
   input logic        tight_buf_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic       wr_sc;
   logic [7:0] wd_q;
   assign wr_sc = avs_write && !avs_waitrequest && avs_address == 2'h1 && avs_byteenable[0];
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         wd_q <= 8'h00;
      else if (wr_sc)
         wd_q <= avs_writedata[7:0];
   end
   a_trim_reload: assert property ($fell(srst) |=> trim_code == $past(factory_trim))
      else $error("trim not loaded from factory value");
   a_trim_write: assert property (avs_write && !avs_waitrequest && avs_address == 2'h0
      && avs_byteenable[0] |=> trim_code == $past(avs_writedata[7:0]))
      else $error("trim write lost");
   a_bandgap_decode: assert property (wr_sc |-> ##2 bandgap_en == (wd_q[7] && wd_q[1:0] != 2'h3))
      else $error("bandgap enable wrong");
   a_mode_decode: assert property (wr_sc |-> ##2 lp_buf_en == ({wd_q[7], wd_q[1:0]} == 3'h5)
      && tight_buf_en == ({wd_q[7], wd_q[1:0]} == 3'h6))
      else $error("buffer enable wrong");
   a_buf_exclusive: assert property (lp_buf_en || tight_buf_en |-> bandgap_en
      && !(lp_buf_en && tight_buf_en))
      else $error("buffer without bandgap");
   a_wait_state: assert property ($rose(avs_read || avs_write) && clock_gate_ctrl_one
      && $past(clock_gate_ctrl_one) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state count wrong");
   a_gated_hold: assert property (!clock_gate_ctrl_one && !$past(clock_gate_ctrl_one)
      && (avs_read || avs_write) |-> avs_waitrequest)
      else $error("gated access answered");
   a_sc_zeros: assert property (avs_read && !avs_waitrequest && avs_address == 2'h1
      |-> avs_readdata[6:3] == 4'h0 && avs_readdata[31:8] == 24'h0)
      else $error("unused bits not zero");
endmodule

bind vref_ctrl vref_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) props (.sys_clk, .srst,
   .factory_trim, .clock_gate_ctrl_one, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .trim_code, .bandgap_en, .lp_buf_en,
   .tight_buf_en);

// File: hw/vref_ctrl.sv
`timescale 1ns/1ps
module vref_ctrl
#(
   parameter int unsigned STARTUP_CYCLES = vref_pkg::STARTUP_CYC
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  factory_trim,
   input  wire logic        clock_gate_ctrl_one,
   input  wire logic        third_stop_mode,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [7:0]       trim_code,
   output logic             bandgap_en,
   output logic             lp_buf_en,
   output logic             tight_buf_en,
   output logic             reference_out_pin_en,
   output logic             irq
);

   logic [7:0]   trim_q;
   logic         ref_en_q;
   logic [1:0]   mode_q;
   logic [1:0]   irq_stat_q;
   logic [1:0]   irq_mask_q;
   logic [31:0]  rdata_q;
   logic         ack_q;
   logic         gate_q;
   logic         trim_load_q;
   logic         active;
   logic         stable;
   logic         stable_prev_q;
   logic         wr_acc;
   logic         rd_acc;
   logic [7:0]   sc_rd;
   vref_pkg::analog_ctrl_s ctl_d;
   vref_pkg::analog_ctrl_s ctl_q;
   logic         irq_q;

   // bus decode, interrupt and read helpers
   logic         waitrequest_q;
   logic         wr_trim;
   logic         wr_sc;
   logic         wr_stat;
   logic         wr_mask;
   logic [1:0]   irq_evt;
   logic [1:0]   irq_clr;
   logic [1:0]   irq_stat_d;
   logic [31:0]  rd_mux;

   // gated bus clock modelled as an enable on bus access; set after reset
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         gate_q <= 1'b1;
      end
      else
      begin
         gate_q <= clock_gate_ctrl_one;
      end
   end

   // one wait state: answer on second cycle; with gate closed no access done
   assign wr_acc = avs_write && gate_q && !ack_q;
   assign rd_acc = avs_read && gate_q && !ack_q;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= (wr_acc || rd_acc);
      end
   end

   // registered so the bus sees a clean level; idles high
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         waitrequest_q <= 1'b1;
      end
      else
      begin
         waitrequest_q <= !(wr_acc || rd_acc);
      end
   end

   assign avs_waitrequest = waitrequest_q;

   // register select for a write taken this cycle
   always_comb
   begin
      wr_trim = 1'b0;
      wr_sc   = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (wr_acc && avs_byteenable[0])
      begin
         case (avs_address)
            vref_pkg::IDX_TRIM[1:0]:     wr_trim = 1'b1;
            vref_pkg::IDX_SC[1:0]:       wr_sc   = 1'b1;
            vref_pkg::IDX_IRQ_STAT[1:0]: wr_stat = 1'b1;
            vref_pkg::IDX_IRQ_MASK[1:0]: wr_mask = 1'b1;
            default:                     wr_trim = 1'b0;
         endcase
      end
   end

   // factory trim captured by a clock after reset, not by the reset itself
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         trim_load_q <= 1'b1;
      end
      else
      begin
         trim_load_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (trim_load_q)
      begin
         trim_q <= factory_trim;
      end
      else if (wr_trim)
      begin
         trim_q <= avs_writedata[7:0];
      end
   end

   // status/control: only enable and mode stored
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ref_en_q <= vref_pkg::SC_RESET[vref_pkg::SC_EN_BIT];
         mode_q   <= vref_pkg::SC_RESET[vref_pkg::SC_MODE_LO +: 2];
      end
      else if (wr_sc)
      begin
         ref_en_q <= avs_writedata[vref_pkg::SC_EN_BIT];
         mode_q   <= avs_writedata[vref_pkg::SC_MODE_LO +: 2];
      end
   end

   // reserved mode counts as disabled; third stop mode does not stop it
   assign active = ref_en_q && (mode_q != vref_pkg::MODE_RESERVED);

   // counter is fixed width; the parameter is cut to it on purpose
   localparam logic [vref_pkg::CNT_W-1:0] CNT_W_LIMIT = STARTUP_CYCLES[vref_pkg::CNT_W-1:0];

   vref_startup u_startup
   (
      .sys_clk (sys_clk),
      .srst    (srst),
      .active  (active),
      .limit   (CNT_W_LIMIT),
      .stable  (stable)
   );

   always_comb
   begin
      ctl_d = '0;
      if (active)
      begin
         case (mode_q)
            vref_pkg::MODE_BANDGAP:
            begin
               ctl_d.bandgap_en = 1'b1;
            end
            vref_pkg::MODE_LP_BUF:
            begin
               ctl_d.bandgap_en = 1'b1;
               ctl_d.lp_buf_en  = 1'b1;
            end
            vref_pkg::MODE_TIGHT:
            begin
               ctl_d.bandgap_en   = 1'b1;
               ctl_d.tight_buf_en = 1'b1;
            end
            default:
            begin
               ctl_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ctl_q <= '0;
      end
      else
      begin
         ctl_q <= ctl_d;
      end
   end

   assign bandgap_en           = ctl_q.bandgap_en;
   assign lp_buf_en            = ctl_q.lp_buf_en;
   assign tight_buf_en         = ctl_q.tight_buf_en;
   assign reference_out_pin_en = ctl_q.tight_buf_en;
   assign trim_code            = trim_q;

   // interrupt events: stable rise, enabled with reserved mode
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         stable_prev_q <= 1'b0;
      end
      else
      begin
         stable_prev_q <= stable;
      end
   end

   // one event per status bit
   always_comb
   begin
      irq_evt                            = '0;
      irq_evt[vref_pkg::IRQ_STABLE_BIT]  = stable && !stable_prev_q;
      irq_evt[vref_pkg::IRQ_RESMODE_BIT] = ref_en_q && (mode_q == vref_pkg::MODE_RESERVED);
   end

   assign irq_clr = wr_stat ? avs_writedata[vref_pkg::IRQ_W-1:0] : '0;

   // sticky bits, write one to clear; an event in the same cycle wins
   for (genvar g = 0; g < vref_pkg::IRQ_W; g++)
   begin : g_irq_bit
      assign irq_stat_d[g] = irq_evt[g] || (irq_stat_q[g] && !irq_clr[g]);
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         irq_stat_q <= '0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         irq_mask_q <= vref_pkg::MASK_RESET;
      end
      else if (wr_mask)
      begin
         irq_mask_q <= avs_writedata[vref_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign irq = irq_q;

   // bits 6:3 always zero
   always_comb
   begin
      sc_rd = '0;
      sc_rd[vref_pkg::SC_EN_BIT]        = ref_en_q;
      sc_rd[vref_pkg::SC_STABLE_BIT]    = stable;
      sc_rd[vref_pkg::SC_MODE_LO +: 2]  = mode_q;
   end

   always_comb
   begin
      rd_mux = vref_pkg::UNMAPPED_RD;
      case (avs_address)
         vref_pkg::IDX_TRIM[1:0]:     rd_mux = {24'h000000, trim_q};
         vref_pkg::IDX_SC[1:0]:       rd_mux = {24'h000000, sc_rd};
         vref_pkg::IDX_IRQ_STAT[1:0]: rd_mux = {30'h0, irq_stat_q};
         vref_pkg::IDX_IRQ_MASK[1:0]: rd_mux = {30'h0, irq_mask_q};
         default:                     rd_mux = vref_pkg::UNMAPPED_RD;
      endcase
   end

   // captured on the first request cycle, stands until the next read
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdata_q <= vref_pkg::UNMAPPED_RD;
      end
      else if (rd_acc)
      begin
         rdata_q <= rd_mux;
      end
   end

   assign avs_readdata = rdata_q;

endmodule

// File: hw/vref_pkg.sv
package vref_pkg;

   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 32;

   // register offsets (printed offsets are indices; byte address = 4 * index)
   localparam logic [7:0] IDX_TRIM      = 8'h00;
   localparam logic [7:0] IDX_SC        = 8'h01;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'h02;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'h03;

   // status/control field positions
   localparam int unsigned SC_EN_BIT     = 7;
   localparam int unsigned SC_STABLE_BIT = 2;
   localparam int unsigned SC_MODE_LO    = 0;

   // interrupt status bit positions
   localparam int unsigned IRQ_STABLE_BIT  = 0;
   localparam int unsigned IRQ_RESMODE_BIT = 1;
   localparam int unsigned IRQ_W           = 2;

   localparam logic [1:0] MODE_BANDGAP  = 2'h0;
   localparam logic [1:0] MODE_LP_BUF   = 2'h1;
   localparam logic [1:0] MODE_TIGHT    = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;

   localparam logic [7:0]  SC_RESET     = 8'h00;
   localparam logic [1:0]  MASK_RESET   = 2'h0;
   localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

   // startup time
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned STARTUP_US    = 100;
   localparam int unsigned STARTUP_CYC   = (STARTUP_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W         = 16;

   // trim code step size in microvolts
   localparam int unsigned TRIM_STEP_UV  = 500;

   typedef enum logic [2:0]
   {
      ST_OFF     = 3'b001,
      ST_SETTLE  = 3'b010,
      ST_STABLE  = 3'b100
   } start_state_e;

   typedef struct packed
   {
      logic bandgap_en;
      logic lp_buf_en;
      logic tight_buf_en;
   } analog_ctrl_s;

endpackage

// File: hw/vref_startup.sv
`timescale 1ns/1ps
module vref_startup
(
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic active,
   input  wire logic [vref_pkg::CNT_W-1:0] limit,
   output logic      stable
);

   vref_pkg::start_state_e         state_q;
   logic [vref_pkg::CNT_W-1:0]     cnt_q;

   // counter started on enable rise, cleared on enable fall
   always_ff @(posedge sys_clk)
   begin
      if (srst || !active)
      begin
         state_q <= vref_pkg::ST_OFF;
         cnt_q   <= '0;
      end
      else
      begin
         case (state_q)
            vref_pkg::ST_OFF:
            begin
               state_q <= vref_pkg::ST_SETTLE;
               cnt_q   <= '0;
            end
            vref_pkg::ST_SETTLE:
            begin
               if (cnt_q >= limit - 1'b1)
               begin
                  state_q <= vref_pkg::ST_STABLE;
               end
               else
               begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            vref_pkg::ST_STABLE:
            begin
               state_q <= vref_pkg::ST_STABLE;
            end
            default:
            begin
               state_q <= vref_pkg::ST_OFF;
            end
         endcase
      end
   end

   assign stable = (state_q == vref_pkg::ST_STABLE);

endmodule
